// File: include/its_pkg.sv
// Package for the slave-only two-wire serial interface with bus time-out.
// Assumes a single APB clock domain; byte offsets are word aligned.
package its_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_ENABLE_DEBOUNCE = 8'h00;
   localparam logic [7:0] OFF_STATUS_CONTROL = 8'h04;
   localparam logic [7:0] OFF_SHIFT_DATA = 8'h08;
   localparam logic [7:0] OFF_OWN_ADDRESS = 8'h0c;
   localparam logic [7:0] OFF_TIMEOUT_CONTROL = 8'h10;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int EN_BIT = 1;
   localparam int DEB_LSB = 2;
   localparam int SC_DONE = 7;
   localparam int SC_MATCH = 6;
   localparam int SC_BUSY = 5;
   localparam int SC_TX = 4;
   localparam int SC_ACKDRV = 3;
   localparam int SC_RDREQ = 2;
   localparam int SC_WAKE = 1;
   localparam int SC_ACKRX = 0;
   localparam int TO_EN = 7;
   localparam int TO_FLAG = 6;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_CONTROL_RST = 8'h81;
   localparam logic [7:0] TIMEOUT_CONTROL_RST = 8'h00;
   localparam logic [1:0] DEBOUNCE_RST = 2'h0;
   localparam logic [6:0] OWN_ADDRESS_RST = 7'h00;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int SUB_CLK_HZ = 32_768;
   localparam int SUB_DIV = 32;
   localparam int TICK_CYCLES = (CLK_HZ + SUB_CLK_HZ - 1) / SUB_CLK_HZ;
   // ----------------------------------------------------------------
   // Protocol state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ITS_IDLE = 3'h0,
      ITS_ADDR = 3'h1,
      ITS_AACK = 3'h3,
      ITS_HOLD = 3'h2,
      ITS_DATA = 3'h6,
      ITS_DACK = 3'h7,
      ITS_WAIT = 3'h5
   } its_state_type;
endpackage : its_pkg

// File: design/its_slave.sv
// Slave-only two-wire serial interface with SCL inactivity time-out.
// Assumes SCL and SDA inputs are sampled on pclk; open-drain pins are
// resolved outside; APB slave with zero wait states.
//
// Summary of operation
// - START is SDA falling while SCL stays high.
// - START sets the bus busy flag.
// - Seven address bits shift in MSB first and compare to own address.
// - Address match sets the match flag and raises interrupt.
// - Eighth bit after START is captured as master read request.
// - On match the slave pulls SDA low on ninth clock.
// - SCL held low after match until data write or dummy read.
// - Data bytes are eight bits, MSB first, after address acknowledge.
// - As receiver, the ack drive bit goes onto SDA at ninth clock.
// - As transmitter, master acknowledge is sampled into ack received.
// - Without master acknowledge the slave releases SDA, awaits STOP.
// - Time-out counter starts on match, clears on SCL falling edge.
// - Time-out occurs if period elapses before next SCL falling edge.
// - Time-out counting stops on STOP.
// - Overflow stops counter, clears enable, sets flag, raises interrupt.
// - Time-out resets interface logic and status register only.
// - Hardware only sets the time-out flag; software clears it.
// - Period is select plus one ticks of sub clock over 32.
// - Done flag clears during a byte, sets with interrupt at end.
// - STOP clears the bus busy flag.
// - Own address sits in bits 7 to 1; bit 0 reads zero.
// - Enable rising resets status flags, keeps tx select, ack drive and wake.
`timescale 1ns/1ps
module its_slave
   import its_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES * SUB_DIV
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic irq
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic scl_p;
      logic sda_p;
      its_state_type st;
      logic [3:0] bitn;
      logic [7:0] shreg;
      logic hold;
      logic sda_low;
      logic [7:0] data;
      logic [6:0] own;
      logic enable;
      logic [1:0] deb;
      logic [7:0] sc;
      logic [7:0] toc;
      logic to_run;
      logic [6:0] to_cnt;
      logic [31:0] div;
      logic irq;
      logic [31:0] rdata;
   } its_regs_type;

   its_regs_type r_q, r_d;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = a == o;
   endfunction : hit

   logic scl_now, sda_now, scl_fall, scl_rise, start_ev, stop_ev;
   logic wr_acc, rd_acc, timeout_ev, tick;

   assign scl_now = r_q.scl_s[1];
   assign sda_now = r_q.sda_s[1];
   assign scl_fall = r_q.scl_p & ~scl_now;
   assign scl_rise = ~r_q.scl_p & scl_now;
   assign start_ev = scl_now & r_q.scl_p & r_q.sda_p & ~sda_now;
   assign stop_ev = scl_now & r_q.scl_p & ~r_q.sda_p & sda_now;
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign tick = r_q.div == 32'(TICK_DIV - 1);
   assign timeout_ev = r_q.to_run & tick
                       & (r_q.to_cnt == {1'b0, r_q.toc[5:0]});

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      r_d = r_q;
      r_d.irq = 1'b0;
      r_d.scl_s = {r_q.scl_s[0], scl_in};
      r_d.sda_s = {r_q.sda_s[0], sda_in};
      r_d.scl_p = scl_now;
      r_d.sda_p = sda_now;
      // Time-out prescaler and counter
      r_d.div = tick ? 32'h0 : r_q.div + 32'h1;
      if (r_q.to_run && tick) begin
         r_d.to_cnt = r_q.to_cnt + 7'h1;
      end
      if (scl_fall) begin
         r_d.to_cnt = 7'h0;
         r_d.div = 32'h0;
      end
      // Bus protocol
      if (r_q.enable) begin
         if (scl_fall) begin
            case (r_q.st)
               ITS_AACK: begin
                  r_d.sda_low = 1'b0;
                  r_d.hold = 1'b1;
                  r_d.st = ITS_HOLD;
                  r_d.bitn = 4'h0;
               end
               ITS_DATA: begin
                  if (r_q.bitn == 4'h8) begin
                     r_d.st = ITS_DACK;
                     r_d.sda_low = ~r_q.sc[SC_TX] & ~r_q.sc[SC_ACKDRV];
                  end else if (r_q.sc[SC_TX]) begin
                     r_d.sda_low = ~r_q.shreg[7];
                  end
               end
               ITS_DACK: begin
                  r_d.sda_low = 1'b0;
                  r_d.sc[SC_DONE] = 1'b1;
                  r_d.irq = 1'b1;
                  r_d.hold = 1'b1;
                  r_d.st = ITS_HOLD;
               end
               ITS_ADDR: begin
                  if (r_q.bitn == 4'h8) begin
                     if (hit({r_q.shreg[7:1], 1'b0}, {r_q.own, 1'b0})) begin
                        r_d.sc[SC_MATCH] = 1'b1;
                        r_d.sc[SC_RDREQ] = r_q.shreg[0];
                        r_d.irq = 1'b1;
                        r_d.sda_low = 1'b1;
                        r_d.st = ITS_AACK;
                        r_d.to_run = r_q.toc[TO_EN];
                     end else begin
                        r_d.st = ITS_WAIT;
                     end
                  end
               end
               default: begin
               end
            endcase
         end
         if (scl_rise && (r_q.st == ITS_ADDR || r_q.st == ITS_DATA)) begin
            r_d.shreg = {r_q.shreg[6:0], sda_now};
            r_d.bitn = r_q.bitn + 4'h1;
            if (r_q.st == ITS_DATA && r_q.sc[SC_TX]) begin
               r_d.shreg = {r_q.shreg[6:0], 1'b0};
            end
         end
         if (scl_rise && r_q.st == ITS_DACK) begin
            if (r_q.sc[SC_TX]) begin
               r_d.sc[SC_ACKRX] = sda_now;
            end else begin
               r_d.data = r_q.shreg;
            end
         end
         if (start_ev) begin
            r_d.sc[SC_BUSY] = 1'b1;
            r_d.st = ITS_ADDR;
            r_d.bitn = 4'h0;
            r_d.sda_low = 1'b0;
            r_d.hold = 1'b0;
         end
         if (stop_ev) begin
            r_d.sc[SC_BUSY] = 1'b0;
            r_d.st = ITS_IDLE;
            r_d.sda_low = 1'b0;
            r_d.hold = 1'b0;
            r_d.to_run = 1'b0;
         end
      end
      // Register writes
      if (wr_acc) begin
         case (paddr)
            OFF_ENABLE_DEBOUNCE: begin
               r_d.enable = pwdata[EN_BIT];
               r_d.deb = pwdata[DEB_LSB+1:DEB_LSB];
               if (pwdata[EN_BIT] && !r_q.enable) begin
                  r_d.sc = (STATUS_CONTROL_RST
                            & ~8'h1a) | (r_q.sc & 8'h1a);
                  r_d.st = ITS_IDLE;
               end
            end
            OFF_STATUS_CONTROL: begin
               r_d.sc[SC_TX] = pwdata[SC_TX];
               r_d.sc[SC_ACKDRV] = pwdata[SC_ACKDRV];
               r_d.sc[SC_WAKE] = pwdata[SC_WAKE];
            end
            OFF_SHIFT_DATA: begin
               r_d.data = pwdata[7:0];
               r_d.shreg = pwdata[7:0];
               if (r_q.hold && r_q.sc[SC_TX]) begin
                  r_d.hold = 1'b0;
                  r_d.st = ITS_DATA;
                  r_d.bitn = 4'h0;
                  r_d.sc[SC_DONE] = 1'b0;
                  r_d.sda_low = ~pwdata[7];
               end
            end
            OFF_OWN_ADDRESS: r_d.own = pwdata[7:1];
            OFF_TIMEOUT_CONTROL: begin
               r_d.toc[TO_EN] = pwdata[TO_EN];
               r_d.toc[5:0] = pwdata[5:0];
               if (!pwdata[TO_FLAG]) begin
                  r_d.toc[TO_FLAG] = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      if (rd_acc && paddr == OFF_SHIFT_DATA && r_q.hold
          && !r_q.sc[SC_TX]) begin
         r_d.hold = 1'b0;
         r_d.st = ITS_DATA;
         r_d.bitn = 4'h0;
         r_d.sc[SC_DONE] = 1'b0;
      end
      // Data byte from the transmitter that the master did not acknowledge
      if (r_q.st == ITS_HOLD && r_q.sc[SC_TX] && r_q.sc[SC_ACKRX]
          && !r_q.sc[SC_MATCH] && r_q.hold) begin
         r_d.hold = 1'b0;
         r_d.sda_low = 1'b0;
         r_d.st = ITS_WAIT;
      end
      if (r_q.st == ITS_HOLD && r_q.hold && !r_d.hold) begin
         r_d.sc[SC_MATCH] = 1'b0;
      end
      // Time-out
      if (timeout_ev) begin
         r_d.to_run = 1'b0;
         r_d.toc[TO_EN] = 1'b0;
         r_d.toc[TO_FLAG] = 1'b1;
         r_d.irq = 1'b1;
         r_d.sc = STATUS_CONTROL_RST;
         r_d.st = ITS_IDLE;
         r_d.hold = 1'b0;
         r_d.sda_low = 1'b0;
         r_d.bitn = 4'h0;
      end
      // Read data
      r_d.rdata = 32'h0;
      case (paddr)
         OFF_ENABLE_DEBOUNCE: r_d.rdata[3:0] = {r_q.deb, r_q.enable, 1'b0};
         OFF_STATUS_CONTROL: r_d.rdata[7:0] = r_q.sc;
         OFF_SHIFT_DATA: r_d.rdata[7:0] = r_q.data;
         OFF_OWN_ADDRESS: r_d.rdata[7:0] = {r_q.own, 1'b0};
         OFF_TIMEOUT_CONTROL: r_d.rdata[7:0] = r_q.toc;
         default: r_d.rdata = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q <= '0;
         r_q.scl_s <= 2'h3;
         r_q.sda_s <= 2'h3;
         r_q.scl_p <= 1'b1;
         r_q.sda_p <= 1'b1;
         r_q.st <= ITS_IDLE;
         r_q.sc <= STATUS_CONTROL_RST;
         r_q.toc <= TIMEOUT_CONTROL_RST;
         r_q.deb <= DEBOUNCE_RST;
         r_q.own <= OWN_ADDRESS_RST;
      end else begin
         r_q <= r_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata = r_q.rdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign scl_out = 1'b0;
   assign scl_oe_n = ~r_q.hold;
   assign sda_out = 1'b0;
   assign sda_oe_n = ~r_q.sda_low;
   assign irq = r_q.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking chk_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_start_busy: assert property (
      r_q.enable && start_ev && !timeout_ev |=> r_q.sc[SC_BUSY])
      else $error("busy flag not set by start");
   a_stop_idle: assert property (
      r_q.enable && stop_ev && !timeout_ev |=> !r_q.sc[SC_BUSY] && !r_q.to_run)
      else $error("stop did not clear busy");
   a_timeout_eff: assert property (
      timeout_ev |=> r_q.toc[TO_FLAG] && !r_q.toc[TO_EN] && irq
                     && r_q.sc == STATUS_CONTROL_RST)
      else $error("time-out effects missing");
   a_flag_sticky: assert property (
      r_q.toc[TO_FLAG] && !(wr_acc && paddr == OFF_TIMEOUT_CONTROL)
      |=> r_q.toc[TO_FLAG])
      else $error("time-out flag lost");
   a_match_ack: assert property (
      $rose(r_q.sc[SC_MATCH]) |-> !sda_oe_n && irq)
      else $error("no acknowledge on match");
   a_hold_scl: assert property (
      r_q.hold && !wr_acc && !rd_acc && !timeout_ev && !stop_ev
      && !start_ev && !r_q.sc[SC_ACKRX] |=> !scl_oe_n)
      else $error("clock stretch released early");
   a_tocnt_clr: assert property (
      scl_fall |=> r_q.to_cnt == 7'h0)
      else $error("time-out count not cleared");
   a_addr_low0: assert property (
      rd_acc && paddr == OFF_OWN_ADDRESS |-> prdata[0] == 1'b0)
      else $error("address bit 0 not zero");
endmodule : its_slave

// File: sim/its_master_model.sv
// Bus master model for the two-wire slave: open-drain SCL and SDA.
// Assumes the bench resolves the wires with pull-ups; 1 on an output
// means released.
`timescale 1ns/1ps
module its_master_model (
   input wire logic pclk,
   input wire logic scl,
   input wire logic sda,
   output logic scl_m,
   output logic sda_m
);
   int stalls = 0;
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   task automatic half;
      repeat (8) @(posedge pclk);
   endtask : half
   // Releases SCL and waits while the slave stretches it
   task automatic rise;
      int k;
      k = 0;
      scl_m <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (scl !== 1'b1 && k < 5000);
      if (k >= 5000) stalls++;
   endtask : rise
   task automatic start;
      sda_m <= 1'b1;
      rise;
      half;
      sda_m <= 1'b0;
      half;
      scl_m <= 1'b0;
      half;
   endtask : start
   task automatic bit_io(input logic b, output logic v);
      sda_m <= b;
      half;
      rise;
      half;
      v = sda;
      scl_m <= 1'b0;
      half;
   endtask : bit_io
   task automatic xfer(input logic [7:0] d, input logic ak,
                       output logic [7:0] v, output logic sack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], v[i]);
      end
      bit_io(ak, sack);
   endtask : xfer
   task automatic stop;
      sda_m <= 1'b0;
      half;
      rise;
      half;
      sda_m <= 1'b1;
      half;
   endtask : stop
endmodule : its_master_model

// File: sim/i2c_slave_with_timeout_tb.sv
// Self-checking bench for the two-wire slave with bus time-out.
// Assumes its_pkg and the master model are compiled first.
`timescale 1ns/1ps
module i2c_slave_with_timeout_tb;
   import its_pkg::*;
   localparam int TD = 16;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, r, d, sel;
   logic [31:0] pwdata, prdata, q;
   logic scl_out, scl_oe_n, sda_out, sda_oe_n, irq;
   logic scl_m, sda_m, scl, sda, sack;
   logic [6:0] a;
   int fails = 0, n_tests = 0, irqs = 0, i0;
   assign scl = scl_m & (scl_oe_n | scl_out);
   assign sda = sda_m & (sda_oe_n | sda_out);
   its_slave #(.TICK_DIV(TD)) its_slave_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(scl),
      .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
   its_master_model its_master_model_inst (.pclk(pclk), .scl(scl),
      .sda(sda), .scl_m(scl_m), .sda_m(sda_m));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) if (irq === 1'b1) irqs <= irqs + 1;
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         $display("unexpected %0t: got %h want %h", $time, g, e);
         fails++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] wd);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      q = prdata;
      if (k >= 50) begin
         fails++;
         summarize;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [7:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      chk(q, e);
   endtask : rd
   task automatic xb(input logic [7:0] dd, input logic ak);
      its_master_model_inst.xfer(dd, ak, r, sack);
   endtask : xb
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      void'($urandom(32'hbbba5136));
      a = 7'($urandom());
      d = 8'($urandom());
      sel = {5'h0, 3'($urandom() % 7) + 3'h1};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(OFF_STATUS_CONTROL, {24'h0, STATUS_CONTROL_RST});
      rd(OFF_TIMEOUT_CONTROL, 32'h0);
      rd(8'h1c, 32'h0);
      apb(1'b1, OFF_STATUS_CONTROL, 32'h18);
      apb(1'b1, OFF_ENABLE_DEBOUNCE, 32'h6);
      rd(OFF_STATUS_CONTROL, {24'h0, STATUS_CONTROL_RST | 8'h18});
      rd(OFF_ENABLE_DEBOUNCE, 32'h6);
      apb(1'b1, OFF_OWN_ADDRESS, {24'h0, a, 1'b1});
      rd(OFF_OWN_ADDRESS, {24'h0, a, 1'b0});
      apb(1'b1, OFF_STATUS_CONTROL, 32'h0);
      apb(1'b1, OFF_TIMEOUT_CONTROL, 32'h87);
      // Master writes two bytes, second one refused by the slave
      its_master_model_inst.start();
      apb(1'b0, OFF_STATUS_CONTROL, 32'h0);
      chk(q[SC_BUSY], 1);
      i0 = irqs;
      xb({a, 1'b0}, 1'b1);
      chk(sack, 0);
      chk(irqs - i0, 1);
      apb(1'b0, OFF_STATUS_CONTROL, 32'h0);
      chk(q[SC_MATCH], 1);
      chk(q[SC_RDREQ], 0);
      chk(scl_oe_n, 0);
      apb(1'b0, OFF_SHIFT_DATA, 32'h0);
      chk(scl_oe_n, 1);
      for (int k = 0; k < 2; k++) begin
         i0 = irqs;
         xb(d ^ {8{k[0]}}, 1'b1);
         chk(sack, k);
         chk(irqs - i0, 1);
         apb(1'b0, OFF_STATUS_CONTROL, 32'h0);
         chk(q[SC_DONE], 1);
         apb(1'b1, OFF_STATUS_CONTROL, 32'h08);
         apb(1'b0, OFF_SHIFT_DATA, 32'h0);
         chk(q, {24'h0, d ^ {8{k[0]}}});
      end
      its_master_model_inst.stop();
      apb(1'b0, OFF_STATUS_CONTROL, 32'h0);
      chk(q[SC_BUSY], 0);
      repeat (300) @(posedge pclk);
      rd(OFF_TIMEOUT_CONTROL, 32'h87);
      // Addresses off by the last or the first bit are ignored
      for (int j = 0; j < 7; j += 6) begin
         i0 = irqs;
         its_master_model_inst.start();
         xb({a ^ (7'h1 << j), 1'b0}, 1'b1);
         chk(sack, 1);
         chk(irqs - i0, 0);
         its_master_model_inst.stop();
      end
      // Master reads two bytes and refuses the second
      its_master_model_inst.start();
      xb({a, 1'b1}, 1'b1);
      chk(sack, 0);
      apb(1'b0, OFF_STATUS_CONTROL, 32'h0);
      chk(q[SC_RDREQ], 1);
      apb(1'b1, OFF_STATUS_CONTROL, 32'h10);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, OFF_SHIFT_DATA, {24'h0, d ^ {8{k[0]}}});
         xb(8'hff, k[0]);
         chk(r, d ^ {8{k[0]}});
         apb(1'b0, OFF_STATUS_CONTROL, 32'h0);
         chk(q[SC_ACKRX], k);
      end
      chk(sda_oe_n, 1);
      its_master_model_inst.stop();
      // Slave left stretching until the time-out fires
      apb(1'b1, OFF_TIMEOUT_CONTROL, {24'h0, 8'h80 | sel});
      i0 = irqs;
      its_master_model_inst.start();
      xb({a, 1'b0}, 1'b1);
      repeat ((sel + 1) * TD - 12) @(posedge pclk);
      chk(irqs - i0, 1);
      repeat (52) @(posedge pclk);
      chk(irqs - i0, 2);
      rd(OFF_TIMEOUT_CONTROL, {24'h0, 8'h40 | sel});
      rd(OFF_STATUS_CONTROL, {24'h0, STATUS_CONTROL_RST});
      rd(OFF_OWN_ADDRESS, {24'h0, a, 1'b0});
      rd(OFF_ENABLE_DEBOUNCE, 32'h6);
      chk(scl_oe_n, 1);
      apb(1'b1, OFF_TIMEOUT_CONTROL, 32'h40);
      rd(OFF_TIMEOUT_CONTROL, 32'h40);
      apb(1'b1, OFF_TIMEOUT_CONTROL, 32'h0);
      rd(OFF_TIMEOUT_CONTROL, 32'h0);
      its_master_model_inst.stop();
      chk(its_master_model_inst.stalls, 0);
      summarize;
   end
endmodule : i2c_slave_with_timeout_tb
